/* File: rtl/sbpm_pkg.sv */
// Package with constants of the serial block pin multiplexer
package sbpm_pkg;
    localparam int SBPM_NPIN = 12;
    localparam int SBPM_NSER = 6;
    localparam int SBPM_FW = 5;
    localparam int SBPM_NTOUCH = 5;
    localparam int SBPM_NTOUT = 3;
    localparam int SBPM_CMOD_PIN = 0;
    // Serial block modes
    localparam logic [2:0] MODE_UART6 = 3'h0;
    localparam logic [2:0] MODE_UART4 = 3'h1;
    localparam logic [2:0] MODE_UART2 = 3'h2;
    localparam logic [2:0] MODE_SPIM = 3'h3;
    localparam logic [2:0] MODE_SPIS = 3'h4;
    localparam logic [2:0] MODE_I2CM = 3'h5;
    localparam logic [2:0] MODE_I2CS = 3'h6;
    localparam logic [2:0] SBPM_MODE_RST = MODE_UART6;
    // General-purpose pin functions
    localparam logic [4:0] FN_TRI = 5'h00;
    localparam logic [4:0] FN_DRV1 = 5'h01;
    localparam logic [4:0] FN_DRV0 = 5'h02;
    localparam logic [4:0] FN_POWER = 5'h03;
    localparam logic [4:0] FN_TX_ACTIVITY_LED_N = 5'h04;
    localparam logic [4:0] FN_RX_ACTIVITY_LED_N = 5'h05;
    localparam logic [4:0] FN_ANYLED = 5'h06;
    localparam logic [4:0] FN_CHG0 = 5'h07;
    localparam logic [4:0] FN_CHG1 = 5'h08;
    localparam logic [4:0] FN_BUSDET = 5'h09;
    localparam logic [4:0] FN_TIN0 = 5'h0A;
    localparam logic [4:0] FN_TOUT0 = 5'h0F;
    localparam logic [4:0] FN_CMOD = 5'h12;
    localparam logic [4:0] FN_SHIELD = 5'h13;
    localparam logic [4:0] FN_RS485 = 5'h14;
    // Pin 11 down to pin 0; pins 2..7 idle while the serial block owns them
    localparam logic [11:0][4:0] SBPM_FUNC_RST = {FN_POWER, FN_TRI,
        FN_TRI, FN_TRI, FN_TRI, FN_TRI, FN_TRI, FN_TRI, FN_TRI, FN_TRI,
        FN_RX_ACTIVITY_LED_N, FN_TX_ACTIVITY_LED_N};
    // Serial pin index to general-purpose pin index
    localparam int SBPM_SER_GPIO [SBPM_NSER] = '{6, 2, 3, 4, 5, 7};
    // Charger state index
    localparam logic [1:0] CHG_UNCFG = 2'h0;
    localparam logic [1:0] CHG_STD = 2'h1;
    localparam logic [1:0] CHG_DED = 2'h2;
    localparam logic [1:0] CHG_SUSP = 2'h3;
    // Engine input idle levels: rxd,dsr_n,cts_n,ssel,sclk,mosi,miso,scl,sda
    localparam logic [8:0] SBPM_ENG_IDLE = 9'h1E3;
endpackage

/* File: rtl/sbpm_ser_if.sv */
// Serial engine signals between the top and the serial pin map
`timescale 1ns/1ps
interface sbpm_ser_if;
    logic uart_txd;
    logic uart_rts_n;
    logic uart_dtr_n;
    logic uart_rxd;
    logic uart_dsr_n;
    logic uart_cts_n;
    logic spi_ssel_o;
    logic spi_sclk_o;
    logic spi_mosi_o;
    logic spi_miso_o;
    logic spi_ssel_i;
    logic spi_sclk_i;
    logic spi_mosi_i;
    logic spi_miso_i;
    logic i2c_scl_o;
    logic i2c_sda_o;
    logic i2c_scl_i;
    logic i2c_sda_i;
    modport eng (output uart_txd, uart_rts_n, uart_dtr_n, spi_ssel_o,
        spi_sclk_o, spi_mosi_o, spi_miso_o, i2c_scl_o, i2c_sda_o,
        input uart_rxd, uart_dsr_n, uart_cts_n, spi_ssel_i, spi_sclk_i,
        spi_mosi_i, spi_miso_i, i2c_scl_i, i2c_sda_i);
    modport pins (input uart_txd, uart_rts_n, uart_dtr_n, spi_ssel_o,
        spi_sclk_o, spi_mosi_o, spi_miso_o, i2c_scl_o, i2c_sda_o,
        output uart_rxd, uart_dsr_n, uart_cts_n, spi_ssel_i, spi_sclk_i,
        spi_mosi_i, spi_miso_i, i2c_scl_i, i2c_sda_i);
endinterface

/* File: rtl/sbpm_serial_map.sv */
// Serial pin routing per serial block mode
`timescale 1ns/1ps
module sbpm_serial_map (
    sbpm_ser_if.pins ser,
    input wire logic [2:0] mode,
    input wire logic [5:0] pin_in,
    output logic [5:0] own,
    output logic [5:0] drv,
    output logic [5:0] oe_n
);
    import sbpm_pkg::*;

    always_comb
    begin
        own = '0;
        drv = '0;
        oe_n = '1;
        {ser.uart_rxd, ser.uart_dsr_n, ser.uart_cts_n, ser.spi_ssel_i,
            ser.spi_sclk_i, ser.spi_mosi_i, ser.spi_miso_i,
            ser.i2c_scl_i, ser.i2c_sda_i} = SBPM_ENG_IDLE;
        unique case (mode)
            MODE_UART6, MODE_UART4, MODE_UART2:
            begin
                own[0] = 1'b1;
                ser.uart_rxd = pin_in[0];
                own[4] = 1'b1;
                drv[4] = ser.uart_txd;
                oe_n[4] = 1'b0;
                if (mode != MODE_UART2)
                begin
                    own[3:2] = 2'b11;
                    drv[2] = ser.uart_rts_n;
                    oe_n[2] = 1'b0;
                    ser.uart_cts_n = pin_in[3];
                end
                if (mode == MODE_UART6)
                begin
                    own[1] = 1'b1;
                    ser.uart_dsr_n = pin_in[1];
                    own[5] = 1'b1;
                    drv[5] = ser.uart_dtr_n;
                    oe_n[5] = 1'b0;
                end
            end
            MODE_SPIM:
            begin
                own[4:1] = 4'hF;
                drv[1] = ser.spi_ssel_o;
                ser.spi_miso_i = pin_in[2];
                drv[3] = ser.spi_mosi_o;
                drv[4] = ser.spi_sclk_o;
                oe_n[4:1] = 4'h2;
            end
            MODE_SPIS:
            begin
                own[4:1] = 4'hF;
                ser.spi_ssel_i = pin_in[1];
                drv[2] = ser.spi_miso_o;
                oe_n[2] = 1'b0;
                ser.spi_mosi_i = pin_in[3];
                ser.spi_sclk_i = pin_in[4];
            end
            MODE_I2CM, MODE_I2CS:
            begin
                own[3:2] = 2'b11;
                ser.i2c_scl_i = pin_in[2];
                ser.i2c_sda_i = pin_in[3];
                oe_n[3] = ser.i2c_sda_o;
                if (mode == MODE_I2CM)
                begin
                    oe_n[2] = ser.i2c_scl_o;
                end
            end
            default:
            begin
                own = '0;
            end
        endcase
    end
endmodule

/* File: rtl/sbpm_touch_enc.sv */
// Encoder of the pressed touch button
`timescale 1ns/1ps
module sbpm_touch_enc #(
    parameter int NBTN = 5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic [NBTN-1:0] hit,
    output logic [2:0] code_r
);
    // Lowest button wins when several are touched at once
    function automatic logic [2:0] first_hit(input logic [NBTN-1:0] h);
        logic [2:0] c;
        c = 3'h0;
        for (int i = NBTN - 1; i >= 0; i--)
        begin
            if (h[i])
            begin
                c = 3'(i + 1);
            end
        end
        return c;
    endfunction

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            code_r <= 3'h0;
        end
        else if (clk_en)
        begin
            code_r <= clear ? 3'h0 : first_hit(hit);
        end
    end
endmodule

/* File: rtl/sbpm_pin_mux.sv */
// Serial block and general-purpose pin function multiplexer
//
// Summary of operation
// - Serial block starts in mode 0
// - UART modes 0..2 pin assignments
// - SPI master and slave pin assignments
// - I2C master and slave on pins 3,4
// - Pins support tristate, drive high, low
// - Power-off pin low only when configured
// - LEDs show transmit, receive or either
// - Two pins give configurable charger code
// - Bus-detect pin senses VBUS for charger
// - Five touch inputs, three-bit pressed code
// - Any function on any pin, except CMOD
// - Suspend output with selectable polarity
// - Chip reset low tristates every pin
// - D+ pull-up only while VBUS present
// - Default pin functions after reset
// - RS485 enable while character pending
`timescale 1ns/1ps
module sbpm_pin_mux (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic chip_reset_n,
    input wire logic cfg_load,
    input wire logic [2:0] cfg_mode,
    input wire logic [sbpm_pkg::SBPM_NPIN-1:0][4:0] cfg_func,
    input wire logic cfg_charger_en,
    input wire logic [3:0][1:0] cfg_chg_map,
    input wire logic cfg_susp_high,
    input wire logic cfg_wake_high,
    input wire logic usb_configured,
    input wire logic usb_suspended,
    input wire logic usb_tx_act,
    input wire logic usb_rx_act,
    input wire logic charger_dedicated,
    input wire logic vbus_pin,
    input wire logic uart_tx_pending,
    input wire logic uart_txd,
    input wire logic uart_rts_n,
    input wire logic uart_dtr_n,
    input wire logic spi_ssel_o,
    input wire logic spi_sclk_o,
    input wire logic spi_mosi_o,
    input wire logic spi_miso_o,
    input wire logic i2c_scl_o,
    input wire logic i2c_sda_o,
    output logic uart_rxd,
    output logic uart_dsr_n,
    output logic uart_cts_n,
    output logic spi_ssel_i,
    output logic spi_sclk_i,
    output logic spi_mosi_i,
    output logic spi_miso_i,
    output logic i2c_scl_i,
    output logic i2c_sda_i,
    input wire logic [sbpm_pkg::SBPM_NPIN-1:0] gpio_in,
    output logic [sbpm_pkg::SBPM_NPIN-1:0] gpio_out,
    output logic [sbpm_pkg::SBPM_NPIN-1:0] gpio_oe_n,
    output logic suspend_out,
    output logic suspend_oe_n,
    input wire logic wake_in,
    output logic wake_req,
    output logic usb_dplus_pullup,
    output logic vbus_present,
    output logic [2:0] mode
);
    import sbpm_pkg::*;

    sbpm_ser_if ser ();

    logic [2:0] mode_r;
    logic [SBPM_NPIN-1:0][4:0] func_r;
    logic [SBPM_NPIN-1:0] pin_out_r;
    logic [SBPM_NPIN-1:0] pin_oe_n_r;
    logic [SBPM_NPIN-1:0] pin_out_nxt;
    logic [SBPM_NPIN-1:0] pin_oe_n_nxt;
    logic [SBPM_NPIN-1:0] ser_own_g;
    logic [SBPM_NPIN-1:0] ser_drv_g;
    logic [SBPM_NPIN-1:0] ser_oe_n_g;
    logic [5:0] ser_pin_in;
    logic [5:0] ser_own;
    logic [5:0] ser_drv;
    logic [5:0] ser_oe_n;
    logic [8:0] eng_in_r;
    logic [1:0] chg_code_r;
    logic [1:0] chg_idx;
    logic [SBPM_NTOUCH-1:0] touch_hit;
    logic [2:0] touch_code;
    logic busdet_any;
    logic vbus_r;
    logic susp_r;
    logic wake_r;

    assign ser.uart_txd = uart_txd;
    assign ser.uart_rts_n = uart_rts_n;
    assign ser.uart_dtr_n = uart_dtr_n;
    assign ser.spi_ssel_o = spi_ssel_o;
    assign ser.spi_sclk_o = spi_sclk_o;
    assign ser.spi_mosi_o = spi_mosi_o;
    assign ser.spi_miso_o = spi_miso_o;
    assign ser.i2c_scl_o = i2c_scl_o;
    assign ser.i2c_sda_o = i2c_sda_o;
    assign {uart_rxd, uart_dsr_n, uart_cts_n, spi_ssel_i, spi_sclk_i,
        spi_mosi_i, spi_miso_i, i2c_scl_i, i2c_sda_i} = eng_in_r;
    assign mode = mode_r;

    // Stored configuration; chip reset also returns it to defaults
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mode_r <= SBPM_MODE_RST;
        end
        else if (clk_en)
        begin
            if (!chip_reset_n)
            begin
                mode_r <= SBPM_MODE_RST;
            end
            else if (cfg_load && cfg_mode <= MODE_I2CS)
            begin
                mode_r <= cfg_mode;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            func_r <= SBPM_FUNC_RST;
        end
        else if (clk_en)
        begin
            if (!chip_reset_n)
            begin
                func_r <= SBPM_FUNC_RST;
            end
            else if (cfg_load)
            begin
                for (int g = 0; g < SBPM_NPIN; g++)
                begin
                    if (cfg_func[g] == FN_CMOD && g != SBPM_CMOD_PIN)
                    begin
                        func_r[g] <= FN_TRI;
                    end
                    else
                    begin
                        func_r[g] <= cfg_func[g];
                    end
                end
            end
        end
    end

    always_comb
    begin
        ser_own_g = '0;
        ser_drv_g = '0;
        ser_oe_n_g = '1;
        ser_pin_in = '0;
        for (int s = 0; s < SBPM_NSER; s++)
        begin
            ser_pin_in[s] = gpio_in[SBPM_SER_GPIO[s]];
            ser_own_g[SBPM_SER_GPIO[s]] = ser_own[s];
            ser_drv_g[SBPM_SER_GPIO[s]] = ser_drv[s];
            ser_oe_n_g[SBPM_SER_GPIO[s]] = ser_oe_n[s];
        end
    end

    sbpm_serial_map u_map (
        .ser(ser.pins),
        .mode(mode_r),
        .pin_in(ser_pin_in),
        .own(ser_own),
        .drv(ser_drv),
        .oe_n(ser_oe_n)
    );

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            eng_in_r <= SBPM_ENG_IDLE;
        end
        else if (clk_en)
        begin
            eng_in_r <= {ser.uart_rxd, ser.uart_dsr_n, ser.uart_cts_n,
                ser.spi_ssel_i, ser.spi_sclk_i, ser.spi_mosi_i,
                ser.spi_miso_i, ser.i2c_scl_i, ser.i2c_sda_i};
        end
    end

    // Touch and bus-detect inputs gathered from their pins
    always_comb
    begin
        touch_hit = '0;
        busdet_any = 1'b0;
        for (int g = 0; g < SBPM_NPIN; g++)
        begin
            for (int k = 0; k < SBPM_NTOUCH; k++)
            begin
                if (func_r[g] == FN_TIN0 + 5'(k))
                begin
                    touch_hit[k] = touch_hit[k] | gpio_in[g];
                end
            end
            if (func_r[g] == FN_BUSDET)
            begin
                busdet_any = busdet_any | gpio_in[g];
            end
        end
    end

    sbpm_touch_enc #(
        .NBTN(SBPM_NTOUCH)
    ) u_touch (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .clear(!chip_reset_n),
        .hit(touch_hit),
        .code_r(touch_code)
    );

    // Absent VBUS always reports the unconfigured code
    always_comb
    begin
        if (!vbus_r)
        begin
            chg_idx = CHG_UNCFG;
        end
        else if (usb_suspended)
        begin
            chg_idx = CHG_SUSP;
        end
        else if (charger_dedicated)
        begin
            chg_idx = CHG_DED;
        end
        else if (usb_configured)
        begin
            chg_idx = CHG_STD;
        end
        else
        begin
            chg_idx = CHG_UNCFG;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            vbus_r <= 1'b0;
            chg_code_r <= 2'h0;
        end
        else if (clk_en)
        begin
            // Divider pin used with charger detect
            vbus_r <= cfg_charger_en ? busdet_any : vbus_pin;
            chg_code_r <= cfg_chg_map[chg_idx];
        end
    end

    assign usb_dplus_pullup = vbus_r & chip_reset_n;
    assign vbus_present = vbus_r;

    always_comb
    begin
        for (int g = 0; g < SBPM_NPIN; g++)
        begin
            pin_out_nxt[g] = 1'b0;
            pin_oe_n_nxt[g] = 1'b0;
            case (func_r[g])
                FN_DRV1: pin_out_nxt[g] = 1'b1;
                FN_DRV0: pin_out_nxt[g] = 1'b0;
                FN_POWER: pin_out_nxt[g] = !(usb_configured
                    && !usb_suspended);
                FN_TX_ACTIVITY_LED_N: pin_out_nxt[g] = !usb_tx_act;
                FN_RX_ACTIVITY_LED_N: pin_out_nxt[g] = !usb_rx_act;
                FN_ANYLED: pin_out_nxt[g] = !(usb_tx_act || usb_rx_act);
                FN_CHG0: pin_out_nxt[g] = chg_code_r[0];
                FN_CHG1: pin_out_nxt[g] = chg_code_r[1];
                FN_TOUT0: pin_out_nxt[g] = touch_code[0];
                FN_TOUT0 + 5'h01: pin_out_nxt[g] = touch_code[1];
                FN_TOUT0 + 5'h02: pin_out_nxt[g] = touch_code[2];
                FN_RS485: pin_out_nxt[g] = uart_tx_pending;
                default: pin_oe_n_nxt[g] = 1'b1;
            endcase
            // Serial block ownership overrides the pin function
            if (ser_own_g[g])
            begin
                pin_out_nxt[g] = ser_drv_g[g];
                pin_oe_n_nxt[g] = ser_oe_n_g[g];
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_out_r <= '0;
            pin_oe_n_r <= '1;
        end
        else if (clk_en)
        begin
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            susp_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else if (clk_en)
        begin
            susp_r <= usb_suspended ~^ cfg_susp_high;
            wake_r <= wake_in ~^ cfg_wake_high;
        end
    end

    assign gpio_oe_n = chip_reset_n ? pin_oe_n_r : '1;
    assign gpio_out = pin_out_r;
    assign suspend_out = susp_r;
    assign suspend_oe_n = !chip_reset_n;
    assign wake_req = wake_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_mode_held: assert property ((clk_en && !cfg_load && chip_reset_n)
        |=> $stable(mode_r)) else $error("mode changed without load");
    a_uart_txd_pin: assert property ((clk_en && mode_r == MODE_UART6)
        |=> gpio_out[5] == $past(uart_txd) && !pin_oe_n_r[5])
        else $error("txd not on pin 5");
    a_spi_sclk_pin: assert property ((clk_en && mode_r == MODE_SPIM)
        |=> gpio_out[5] == $past(spi_sclk_o) && !pin_oe_n_r[5])
        else $error("sclk not on pin 5");
    a_i2c_scl_od: assert property ((clk_en && mode_r == MODE_I2CM)
        |=> !gpio_out[3] && pin_oe_n_r[3] == $past(i2c_scl_o))
        else $error("scl not open drain");
    a_static_drive: assert property ((clk_en && func_r[8] == FN_DRV0
        && !ser_own_g[8]) |=> !gpio_out[8] && !pin_oe_n_r[8])
        else $error("drive low not held");
    a_power_off_pin: assert property ((clk_en && func_r[11] == FN_POWER)
        |=> gpio_out[11] == !($past(usb_configured)
        && !$past(usb_suspended))) else $error("power-off wrong");
    a_led_active_low: assert property ((clk_en && func_r[8] == FN_TX_ACTIVITY_LED_N)
        |=> gpio_out[8] == !$past(usb_tx_act))
        else $error("tx led wrong");
    a_reset_tristate: assert property (!chip_reset_n |-> &gpio_oe_n
        && suspend_oe_n && !usb_dplus_pullup)
        else $error("pin driven in reset");
    a_pullup_vbus: assert property ((clk_en && !cfg_charger_en
        && !vbus_pin) |=> !usb_dplus_pullup)
        else $error("pull-up without vbus");
    a_suspend_pol: assert property (clk_en |=> suspend_out ==
        ($past(usb_suspended) ~^ $past(cfg_susp_high)))
        else $error("suspend level wrong");
    a_rs485_enable: assert property ((clk_en && func_r[8] == FN_RS485)
        |=> gpio_out[8] == $past(uart_tx_pending))
        else $error("rs485 enable wrong");

    c_spi_slave: cover property (mode_r == MODE_SPIS ##1 mode_r == MODE_I2CM);
    c_touch_code: cover property (touch_code == 3'h5);
    c_charger_susp: cover property (vbus_r && chg_idx == CHG_SUSP);
endmodule

/* File: test/sbpm_far_end.sv */
// Model of the parts wired to the multiplexed pins
`timescale 1ns/1ps
module sbpm_far_end (
    input wire logic [11:0] gpio_out,
    input wire logic [11:0] gpio_oe_n,
    input wire logic [11:0] ext_val,
    input wire logic wake_level,
    output logic [11:0] gpio_in,
    output logic wake_in
);
    import sbpm_pkg::*;
    // Released pins show the far part's level, never a stale value
    always_comb
    begin
        for (int i = 0; i < SBPM_NPIN; i++)
        begin
            gpio_in[i] = gpio_oe_n[i] ? ext_val[i] : gpio_out[i];
        end
    end
    assign wake_in = wake_level;
endmodule

/* File: test/tb.sv */
// Testbench of the serial block pin multiplexer
`timescale 1ns/1ps
module tb;
    import sbpm_pkg::*;
    typedef struct packed {
        logic [4:0] fn;
        logic [6:0] st;
        logic [1:0] exp;
    } sbpm_row_t;
    logic clk, reset, clk_en, chip_reset_n, cfg_load, cfg_charger_en;
    logic cfg_susp_high, cfg_wake_high, wake_level;
    logic [2:0] cfg_mode, mode;
    logic [11:0][4:0] cfg_func;
    logic [3:0][1:0] cfg_chg_map;
    logic usb_configured, usb_suspended, usb_tx_act, usb_rx_act;
    logic charger_dedicated, vbus_pin, uart_tx_pending;
    logic uart_txd, uart_rts_n, uart_dtr_n, spi_ssel_o, spi_sclk_o;
    logic spi_mosi_o, spi_miso_o, i2c_scl_o, i2c_sda_o;
    logic uart_rxd, uart_dsr_n, uart_cts_n, spi_ssel_i, spi_sclk_i;
    logic spi_mosi_i, spi_miso_i, i2c_scl_i, i2c_sda_i;
    logic [11:0] gpio_in, gpio_out, gpio_oe_n, ext_val;
    logic suspend_out, suspend_oe_n, wake_in, wake_req;
    logic usb_dplus_pullup, vbus_present;
    int fails, check_count, cyc;
    // Serial pin 5..0 expected output enables per mode, 1 is released
    logic [5:0] mexp [7] = '{6'h0B, 6'h2B, 6'h2F, 6'h25, 6'h3B, 6'h33,
        6'h37};
    // State bits: configured, suspended, tx, rx, pending, vbus, dedicated
    sbpm_row_t rows [20] = '{'{FN_TRI, 7'h00, 2'h2},
        '{FN_DRV1, 7'h00, 2'h1}, '{FN_DRV0, 7'h00, 2'h0},
        '{FN_POWER, 7'h40, 2'h0}, '{FN_POWER, 7'h00, 2'h1},
        '{FN_POWER, 7'h60, 2'h1}, '{FN_TX_ACTIVITY_LED_N, 7'h10, 2'h0},
        '{FN_TX_ACTIVITY_LED_N, 7'h08, 2'h1}, '{FN_RX_ACTIVITY_LED_N, 7'h08, 2'h0},
        '{FN_ANYLED, 7'h10, 2'h0}, '{FN_ANYLED, 7'h08, 2'h0},
        '{FN_ANYLED, 7'h00, 2'h1}, '{FN_RS485, 7'h04, 2'h1},
        '{FN_RS485, 7'h00, 2'h0}, '{FN_CMOD, 7'h00, 2'h2},
        '{FN_CHG0, 7'h42, 2'h1}, '{FN_CHG1, 7'h42, 2'h0},
        '{FN_CHG1, 7'h40, 2'h1}, '{FN_CHG0, 7'h43, 2'h1},
        '{FN_CHG0, 7'h62, 2'h0}};

    sbpm_pin_mux i_dut (.clk, .reset, .clk_en, .chip_reset_n, .cfg_load,
        .cfg_mode, .cfg_func, .cfg_charger_en, .cfg_chg_map,
        .cfg_susp_high, .cfg_wake_high, .usb_configured, .usb_suspended,
        .usb_tx_act, .usb_rx_act, .charger_dedicated, .vbus_pin,
        .uart_tx_pending, .uart_txd, .uart_rts_n, .uart_dtr_n, .spi_ssel_o,
        .spi_sclk_o, .spi_mosi_o, .spi_miso_o, .i2c_scl_o, .i2c_sda_o,
        .uart_rxd, .uart_dsr_n, .uart_cts_n, .spi_ssel_i, .spi_sclk_i,
        .spi_mosi_i, .spi_miso_i, .i2c_scl_i, .i2c_sda_i, .gpio_in,
        .gpio_out, .gpio_oe_n, .suspend_out, .suspend_oe_n, .wake_in,
        .wake_req, .usb_dplus_pullup, .vbus_present, .mode);
    sbpm_far_end i_far (.gpio_out, .gpio_oe_n, .ext_val, .wake_level,
        .gpio_in, .wake_in);

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Pins follow a new load one edge after the mode register
    task automatic load(input logic [2:0] m);
        cfg_mode = m;
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
        tick(3);
    endtask

    task automatic finish_test;
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            finish_test;
        end
    end

    initial
    begin
        fails = 0;
        check_count = 0;
        cyc = 0;
        {reset, clk_en, chip_reset_n, cfg_load, cfg_mode} = 7'h70;
        cfg_func = '0;
        cfg_chg_map = 8'h36;
        {cfg_charger_en, cfg_susp_high, cfg_wake_high, wake_level} = 4'h0;
        {usb_configured, usb_suspended, usb_tx_act, usb_rx_act} = 4'h0;
        {charger_dedicated, vbus_pin, uart_tx_pending} = 3'h0;
        {uart_txd, uart_rts_n, uart_dtr_n, spi_ssel_o, spi_sclk_o} = 5'h08;
        {spi_mosi_o, spi_miso_o, i2c_scl_o, i2c_sda_o} = 4'hC;
        ext_val = 12'hFFF;
        tick(8);
        reset = 1'b0;
        tick(2);
        check(mode, 3'h0); // Start mode
        check(gpio_oe_n, 12'h754); // Default drive
        check(gpio_out[0], 1'b1); // Idle led off
        check(gpio_out[11], 1'b1); // Unconfigured power off
        for (int r = 0; r < 20; r++)
        begin
            {usb_configured, usb_suspended, usb_tx_act, usb_rx_act,
                uart_tx_pending, vbus_pin, charger_dedicated} = rows[r].st;
            cfg_func[8] = rows[r].fn;
            load(3'h0);
            check(gpio_oe_n[8], rows[r].exp[1]); // Drive
            if (!rows[r].exp[1])
                check(gpio_out[8], rows[r].exp[0]);
        end
        for (int m = 0; m < 7; m++)
        begin
            load(m[2:0]);
            check(mode, m[2:0]); // Mode taken
            for (int k = 0; k < SBPM_NSER; k++)
                check(gpio_oe_n[SBPM_SER_GPIO[k]], mexp[m][k]);
            if (m == 3)
            begin
                check(gpio_out[4], 1'b1); // Master data out
                ext_val[3] = 1'b0;
                tick(2);
                check(spi_miso_i, 1'b0); // Master data
                ext_val[3] = 1'b1;
            end
            if (m == 0)
            begin
                ext_val[6] = 1'b0;
                tick(2);
                check(uart_rxd, 1'b0); // Receive data
                ext_val[6] = 1'b1;
            end
            if (m == 6)
            begin
                check(i2c_sda_i, 1'b0); // Held data reads back
                check(i2c_scl_i, 1'b1); // Released clock
            end
        end
        load(3'h7);
        check(mode, 3'h6); // Unused code kept
        vbus_pin = 1'b1;
        tick(2);
        check(usb_dplus_pullup, 1'b1); // Pull-up on
        chip_reset_n = 1'b0;
        #1;
        check(gpio_oe_n, 12'hFFF); // All released
        check(suspend_oe_n, 1'b1); // Suspend released
        tick(1);
        chip_reset_n = 1'b1;
        tick(1);
        check(mode, 3'h0); // Back to start
        check(gpio_oe_n, 12'h754); // Defaults again
        vbus_pin = 1'b0;
        tick(2);
        check(usb_dplus_pullup, 1'b0); // Pull-up off
        cfg_func[9] = FN_BUSDET;
        cfg_charger_en = 1'b1;
        load(3'h0);
        check(vbus_present, 1'b1); // Sensed bus
        ext_val[9] = 1'b0;
        tick(2);
        check(vbus_present, 1'b0); // Sensed bus
        cfg_func[0] = FN_TOUT0;
        cfg_func[1] = FN_TOUT0 + 5'h01;
        cfg_func[11] = FN_TOUT0 + 5'h02;
        cfg_func[8] = FN_TIN0 + 5'h01;
        cfg_func[10] = FN_TIN0 + 5'h04;
        load(3'h0);
        check({gpio_out[11], gpio_out[1:0]}, 3'h2); // Lowest button
        ext_val[8] = 1'b0;
        tick(2);
        check({gpio_out[11], gpio_out[1:0]}, 3'h5); // Pressed code
        check(gpio_oe_n[1:0], 2'h0); // Code pins driven
        usb_suspended = 1'b1;
        cfg_susp_high = 1'b1;
        tick(2);
        check(suspend_out, 1'b1); // High polarity
        cfg_susp_high = 1'b0;
        tick(2);
        check(suspend_out, 1'b0); // Low polarity
        tick(2);
        check(wake_req, 1'b1); // Low wake
        wake_level = 1'b1;
        tick(2);
        check(wake_req, 1'b0); // Low wake idle
        cfg_wake_high = 1'b1;
        tick(2);
        check(wake_req, 1'b1); // High wake
        finish_test;
    end
endmodule
